/* File: design/pwp_gate.sv */
`timescale 1ns/1ns
// ==========================================================
// Write gate in front of one group's peripherals
module pwp_gate
  import pwp_pkg::*;
#(
  parameter int WIDTH = PWP_DATA_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] prot,
  input wire logic [WIDTH-1:0] wr_req,
  output logic [WIDTH-1:0] wr_grant_ff,
  output logic [WIDTH-1:0] wr_deny_ff
);

  // Gate covers at most one bus word of protection bits
  if (WIDTH < 1 || WIDTH > PWP_DATA_W) begin : g_bad_width
    $error("pwp_gate: WIDTH must lie between 1 and PWP_DATA_W");
  end

  // Whole state of the gate
  typedef struct packed {
    logic [WIDTH-1:0] grant;
    logic [WIDTH-1:0] deny;
  } pwp_gate_s;

  pwp_gate_s st_ff;
  pwp_gate_s nxt_st;

  // Protected peripherals lose their writes
  always_comb begin
    nxt_st.grant = wr_req & ~prot; // [R13]
    nxt_st.deny = wr_req & prot; // [R13]
  end

  // Registered outcome
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wr_grant_ff = st_ff.grant;
  assign wr_deny_ff = st_ff.deny;

endmodule

/* File: design/pwp_group.sv */
`timescale 1ns/1ns
// ==========================================================
// One protection group: clear and set views of one state
module pwp_group
  import pwp_pkg::*;
#(
  parameter logic [31:0] MASK = PWP_GRP0_MASK,
  parameter logic [31:0] RESET_VAL = PWP_GRP0_RESET
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr_stb,
  input wire logic set_stb,
  input wire pwp_wr_s wr,
  output logic [PWP_DATA_W-1:0] prot_ff
);

  // Reset value may only hold implemented bits
  if ((RESET_VAL & ~MASK) != '0) begin : g_bad_reset
    $error("pwp_group: RESET_VAL sets bits outside MASK");
  end

  // Whole state of the group
  typedef struct packed {
    logic [PWP_DATA_W-1:0] prot;
  } pwp_grp_s;

  pwp_grp_s st_ff;
  pwp_grp_s nxt_st;
  logic [PWP_DATA_W-1:0] lane_bits;

  // Next state from clear or set strobe
  always_comb begin
    nxt_st = st_ff;
    // Expand byte strobes to bit enables
    for (int i = 0; i < PWP_STRB_W; i++) begin
      lane_bits[i*8 +: 8] = wr.data[i*8 +: 8] & {8{wr.strb[i]}};
    end
    if (clr_stb) begin
      // Ones clear, zeros leave bits alone [R01] [R02]
      nxt_st.prot = st_ff.prot & ~(lane_bits & MASK);
    end else if (set_stb) begin
      // Ones set, zeros leave bits alone [R01] [R05]
      nxt_st.prot = st_ff.prot | (lane_bits & MASK);
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff.prot <= RESET_VAL & MASK; // [R04] [R06]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prot_ff = st_ff.prot;

endmodule

/* File: design/pwp_pkg.sv */
// ==========================================================
// Shared constants and carriers
package pwp_pkg;

  // Bus geometry
  localparam int PWP_DATA_W = 32;
  localparam int PWP_STRB_W = 4;
  localparam int PWP_ADDR_W = 8;

  // Register map: group bases and offsets inside a group
  localparam logic [7:0] PWP_GRP0_BASE = 8'h00;
  localparam logic [7:0] PWP_GRP1_BASE = 8'h10;
  localparam logic [7:0] PWP_CLR_OFS = 8'h00;
  localparam logic [7:0] PWP_SET_OFS = 8'h04;

  // Group zero bit positions
  localparam int PWP_BIT_POWER_MANAGER = 1;
  localparam int PWP_BIT_SYSTEM_CONTROLLER = 2;
  localparam int PWP_BIT_GENERIC_CLOCK_CTRL = 3;
  localparam int PWP_BIT_WATCHDOG_UNIT = 4;
  localparam int PWP_BIT_CALENDAR_COUNTER = 5;
  localparam int PWP_BIT_EXTERNAL_IRQ_CTRL = 6;

  // Group one bit positions (first bit of each run)
  localparam int PWP_BIT_EVENT_ROUTER = 1;
  localparam int PWP_BIT_SERIAL_UNIT_0 = 2;
  localparam int PWP_NUM_SERIAL_UNITS = 6;
  localparam int PWP_BIT_CONTROL_TIMER_0 = 8;
  localparam int PWP_NUM_CONTROL_TIMERS = 3;
  localparam int PWP_BIT_BASIC_TIMER_THREE = 11;
  localparam int PWP_NUM_BASIC_TIMERS = 5;
  localparam int PWP_BIT_CONVERTER = 16;
  localparam int PWP_BIT_ANALOG_COMPARATOR = 17;

  // Implemented bits and reset values per group
  localparam logic [31:0] PWP_GRP0_MASK = 32'h0000007E;
  localparam logic [31:0] PWP_GRP1_MASK = 32'h0003FFFE;
  localparam logic [31:0] PWP_GRP0_RESET = 32'h00000000;
  localparam logic [31:0] PWP_GRP1_RESET = 32'h00000002;

  // Bus responses
  localparam logic [1:0] PWP_RESP_OKAY = 2'h0;
  localparam logic [1:0] PWP_RESP_SLVERR = 2'h2;

  // Write data with byte lanes, as handed to a group
  typedef struct packed {
    logic [PWP_DATA_W-1:0] data;
    logic [PWP_STRB_W-1:0] strb;
  } pwp_wr_s;

endpackage

/* File: design/pwp_top.sv */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// [R01] Written zero bits leave protection unchanged
// [R02] Clear register ones drop protection; reads state
// [R03] Group zero bits one to six mapped
// [R04] Group zero clear at 0x00, resets unprotected
// [R05] Group zero set at 0x04, same map
// [R06] Group one clear at 0x10, resets 0x2
// [R07] Group one bits 11-15 basic timers
// [R08] Group one bits 2-7 serial units
// [R09] Group one bits 8-10 control timers
// [R10] Group one bit 16 converter, 17 comparator
// [R11] Group one bit 1 event router
// [R12] Byte, halfword and word accesses all work
// [R13] Protected peripherals have their writes blocked
module pwp_top
  import pwp_pkg::*;
#(
  parameter int ADDR_W = PWP_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [PWP_DATA_W-1:0] s_axi_wdata,
  input wire logic [PWP_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [PWP_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral write paths, group zero
  input wire logic [PWP_DATA_W-1:0] grp0_wr_req,
  output logic [PWP_DATA_W-1:0] grp0_wr_grant,
  output logic [PWP_DATA_W-1:0] grp0_wr_deny,
  output logic [PWP_DATA_W-1:0] grp0_prot,
  // Peripheral write paths, group one
  input wire logic [PWP_DATA_W-1:0] grp1_wr_req,
  output logic [PWP_DATA_W-1:0] grp1_wr_grant,
  output logic [PWP_DATA_W-1:0] grp1_wr_deny,
  output logic [PWP_DATA_W-1:0] grp1_prot
);

  // ==========================================================
  // Parameter check

  // Narrowest address that still reaches the highest register
  localparam int ADDR_W_MIN = $clog2(int'(PWP_GRP1_BASE + PWP_SET_OFS) + 1);

  // Decoder needs room for both group bases
  if (ADDR_W < ADDR_W_MIN || ADDR_W > PWP_ADDR_W) begin : g_bad_addr_w
    $error("pwp_top: ADDR_W must lie between 5 and 8");
  end

  // ==========================================================
  // Peripheral bit map check

  // Run length of a peripheral that owns one bit
  localparam int SINGLE = 1;

  // Mask of a run of adjacent protection bits
  function automatic logic [PWP_DATA_W-1:0] run_mask(input int first, input int count);
    logic [PWP_DATA_W-1:0] m;
    m = '0;
    // One bit per instance, ascending
    for (int i = 0; i < count; i++) begin
      m[first + i] = 1'b1;
    end
    return m;
  endfunction

  // Group zero: one bit per system controller
  localparam logic [PWP_DATA_W-1:0] GRP0_MAP =
    run_mask(PWP_BIT_POWER_MANAGER, SINGLE)
    | run_mask(PWP_BIT_SYSTEM_CONTROLLER, SINGLE)
    | run_mask(PWP_BIT_GENERIC_CLOCK_CTRL, SINGLE)
    | run_mask(PWP_BIT_WATCHDOG_UNIT, SINGLE)
    | run_mask(PWP_BIT_CALENDAR_COUNTER, SINGLE)
    | run_mask(PWP_BIT_EXTERNAL_IRQ_CTRL, SINGLE); // [R03]

  // Group one: router, serial units, timers, analog
  localparam logic [PWP_DATA_W-1:0] GRP1_MAP =
    run_mask(PWP_BIT_EVENT_ROUTER, SINGLE) // [R11]
    | run_mask(PWP_BIT_SERIAL_UNIT_0, PWP_NUM_SERIAL_UNITS) // [R08]
    | run_mask(PWP_BIT_CONTROL_TIMER_0, PWP_NUM_CONTROL_TIMERS) // [R09]
    | run_mask(PWP_BIT_BASIC_TIMER_THREE, PWP_NUM_BASIC_TIMERS) // [R07]
    | run_mask(PWP_BIT_CONVERTER, SINGLE) // [R10]
    | run_mask(PWP_BIT_ANALOG_COMPARATOR, SINGLE); // [R10]

  // Number of peripherals that share group one
  localparam int GRP1_COUNT = SINGLE + PWP_NUM_SERIAL_UNITS + PWP_NUM_CONTROL_TIMERS
    + PWP_NUM_BASIC_TIMERS + SINGLE + SINGLE;

  // Masks handed to the groups must follow the map
  if (GRP0_MAP != PWP_GRP0_MASK) begin : g_bad_map0
    $error("pwp_top: group zero mask disagrees with the bit map");
  end
  if (GRP1_MAP != PWP_GRP1_MASK) begin : g_bad_map1
    $error("pwp_top: group one mask disagrees with the bit map");
  end

  // Overlapping runs would give one bit to two peripherals
  if ($countones(GRP1_MAP) != GRP1_COUNT) begin : g_overlap1
    $error("pwp_top: group one runs overlap");
  end

  // Group zero starts open, group one with the router locked
  if (PWP_GRP0_RESET != '0) begin : g_bad_rst0
    $error("pwp_top: group zero must reset unprotected"); // [R04]
  end
  if (PWP_GRP1_RESET != run_mask(PWP_BIT_EVENT_ROUTER, SINGLE)) begin : g_bad_rst1
    $error("pwp_top: group one must reset with only the router locked"); // [R06]
  end

  // ==========================================================
  // Bus slave state

  // All slave state in one record
  typedef struct packed {
    logic aw_held;                  // Write address captured
    logic [PWP_ADDR_W-1:0] awaddr;  // Captured write address
    logic w_held;                   // Write data captured
    pwp_wr_s wr;                    // Captured data and strobes
    logic awready;                  // Address channel ready
    logic wready;                   // Data channel ready
    logic bvalid;                   // Response pending
    logic [1:0] bresp;              // Response code
    logic arready;                  // Read address ready
    logic rvalid;                   // Read data pending
    logic [PWP_DATA_W-1:0] rdata;   // Read data
    logic [1:0] rresp;              // Read response code
  } pwp_axi_s;

  pwp_axi_s st_ff;
  pwp_axi_s nxt_st;

  // Strobes toward the two groups
  logic clr0_stb;
  logic set0_stb;
  logic clr1_stb;
  logic set1_stb;

  // Current protection of each group
  logic [PWP_DATA_W-1:0] prot0;
  logic [PWP_DATA_W-1:0] prot1;

  // Widened bus addresses
  logic [PWP_ADDR_W-1:0] aw_word;
  logic [PWP_ADDR_W-1:0] ar_word;

  // ==========================================================
  // Address alignment

  // Low address bits that only pick a byte lane
  localparam logic [PWP_ADDR_W-1:0] LANE_ADDR_MASK = PWP_ADDR_W'(PWP_STRB_W - 1);

  // Word address: byte lanes come from strobes [R12]
  always_comb begin
    aw_word = st_ff.awaddr & ~LANE_ADDR_MASK;
    ar_word = PWP_ADDR_W'(s_axi_araddr) & ~LANE_ADDR_MASK;
  end

  // ==========================================================
  // Slave next-state logic

  always_comb begin
    nxt_st = st_ff;
    clr0_stb = 1'b0;
    set0_stb = 1'b0;
    clr1_stb = 1'b0;
    set1_stb = 1'b0;

    // Accept write address
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = PWP_ADDR_W'(s_axi_awaddr);
    end

    // Accept write data, in either order
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wr.data = s_axi_wdata;
      nxt_st.wr.strb = s_axi_wstrb; // [R12]
    end

    // Both halves held: perform the write
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = PWP_RESP_OKAY;
      if (aw_word == PWP_GRP0_BASE + PWP_CLR_OFS) begin
        clr0_stb = 1'b1; // [R04]
      end else if (aw_word == PWP_GRP0_BASE + PWP_SET_OFS) begin
        set0_stb = 1'b1; // [R05]
      end else if (aw_word == PWP_GRP1_BASE + PWP_CLR_OFS) begin
        clr1_stb = 1'b1; // [R06]
      end else if (aw_word == PWP_GRP1_BASE + PWP_SET_OFS) begin
        set1_stb = 1'b1;
      end else begin
        // Unmapped address: nothing stored
        nxt_st.bresp = PWP_RESP_SLVERR;
      end
    end

    // Response taken by master
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Ready only with a free slot
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

    // Accept read address and fetch data
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = PWP_RESP_OKAY;
      // Both views of a group read the same state [R02] [R05]
      if (ar_word == PWP_GRP0_BASE + PWP_CLR_OFS) begin
        nxt_st.rdata = prot0; // [R03]
      end else if (ar_word == PWP_GRP0_BASE + PWP_SET_OFS) begin
        nxt_st.rdata = prot0; // [R03]
      end else if (ar_word == PWP_GRP1_BASE + PWP_CLR_OFS) begin
        nxt_st.rdata = prot1; // [R07] [R08] [R09] [R10] [R11]
      end else if (ar_word == PWP_GRP1_BASE + PWP_SET_OFS) begin
        nxt_st.rdata = prot1;
      end else begin
        // Unmapped address reads zero with error
        nxt_st.rdata = '0;
        nxt_st.rresp = PWP_RESP_SLVERR;
      end
    end

    // Read data taken by master
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // One read in flight at a time
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ==========================================================
  // Slave state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus outputs straight from the state register
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // ==========================================================
  // Protection groups

  // Group zero: system controllers, starts unprotected
  pwp_group #(
    .MASK(PWP_GRP0_MASK),
    .RESET_VAL(PWP_GRP0_RESET)
  ) u_group_zero (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr_stb(clr0_stb),
    .set_stb(set0_stb),
    .wr(st_ff.wr),
    .prot_ff(prot0)
  );

  // Group one: event router, serial, timers, analog
  pwp_group #(
    .MASK(PWP_GRP1_MASK),
    .RESET_VAL(PWP_GRP1_RESET)
  ) u_group_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr_stb(clr1_stb),
    .set_stb(set1_stb),
    .wr(st_ff.wr),
    .prot_ff(prot1)
  );

  assign grp0_prot = prot0;
  assign grp1_prot = prot1;

  // ==========================================================
  // Peripheral write gates

  // Group zero peripherals
  pwp_gate #(
    .WIDTH(PWP_DATA_W)
  ) u_gate_zero (
    .aclk(aclk),
    .aresetn(aresetn),
    .prot(prot0),
    .wr_req(grp0_wr_req),
    .wr_grant_ff(grp0_wr_grant),
    .wr_deny_ff(grp0_wr_deny)
  );

  // Group one peripherals
  pwp_gate #(
    .WIDTH(PWP_DATA_W)
  ) u_gate_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .prot(prot1),
    .wr_req(grp1_wr_req),
    .wr_grant_ff(grp1_wr_grant),
    .wr_deny_ff(grp1_wr_deny)
  );

endmodule

/* File: verification/pwp_top_properties.sv */
`timescale 1ns/1ns
// ==========================================================
// Checker on the top module's ports
module pwp_top_props
  import pwp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PWP_DATA_W-1:0] grp0_wr_req,
  input wire logic [PWP_DATA_W-1:0] grp0_wr_grant,
  input wire logic [PWP_DATA_W-1:0] grp0_wr_deny,
  input wire logic [PWP_DATA_W-1:0] grp0_prot,
  input wire logic [PWP_DATA_W-1:0] grp1_wr_req,
  input wire logic [PWP_DATA_W-1:0] grp1_wr_grant,
  input wire logic [PWP_DATA_W-1:0] grp1_wr_deny,
  input wire logic [PWP_DATA_W-1:0] grp1_prot
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data not retired");
  property p_prot_cause;
    $past(aresetn) && ($changed(grp0_prot) || $changed(grp1_prot)) |-> $rose(s_axi_bvalid);
  endproperty
  a_prot_cause: assert property (p_prot_cause) else $error("protection moved alone");
  property p_rst_val;
    $rose(aresetn) |-> grp0_prot == PWP_GRP0_RESET && grp1_prot == PWP_GRP1_RESET;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("wrong reset state");
  property p_unused;
    ((grp0_prot & ~PWP_GRP0_MASK) | (grp1_prot & ~PWP_GRP1_MASK)) == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_grant;
    $past(aresetn) |-> grp0_wr_grant == ($past(grp0_wr_req) & ~$past(grp0_prot))
      && grp1_wr_grant == ($past(grp1_wr_req) & ~$past(grp1_prot));
  endproperty
  a_grant: assert property (p_grant) else $error("grant wrong");
  property p_deny;
    $past(aresetn) |-> grp0_wr_deny == ($past(grp0_wr_req) & $past(grp0_prot))
      && grp1_wr_deny == ($past(grp1_wr_req) & $past(grp1_prot));
  endproperty
  a_deny: assert property (p_deny) else $error("deny wrong");
endmodule

bind pwp_top pwp_top_props u_props (.*);

/* File: verification/pwp_top_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// Bench for the protection block
module pwp_top_tb
  import pwp_pkg::*;
;
  // Row: address, data, lanes, expected group states
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] e0;
    logic [31:0] e1;
  } pwp_row_s;
  localparam pwp_row_s ROWS [8] = '{
    '{8'h04, 32'h0000007E, 4'hF, 32'h0000007E, 32'h00000002},
    '{8'h14, 32'hFFFFFFFF, 4'hF, 32'h0000007E, 32'h0003FFFE},
    '{8'h00, 32'h00000018, 4'h1, 32'h00000066, 32'h0003FFFE},
    '{8'h10, 32'h0000F800, 4'h2, 32'h00000066, 32'h000307FE},
    '{8'h10, 32'h000300FF, 4'h4, 32'h00000066, 32'h000007FE},
    '{8'h00, 32'h00000000, 4'hF, 32'h00000066, 32'h000007FE},
    '{8'h10, 32'h000000FC, 4'h1, 32'h00000066, 32'h00000702},
    '{8'h10, 32'h00000702, 4'h3, 32'h00000066, 32'h00000000}
  };
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] grp0_wr_req = 32'hFFFFFFFF;
  logic [31:0] grp0_wr_grant, grp0_wr_deny, grp0_prot;
  logic [31:0] grp1_wr_req = 32'hFFFFFFFF;
  logic [31:0] grp1_wr_grant, grp1_wr_deny, grp1_prot;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic [1:0] r;

  pwp_top dut (.*);

  // Clock, 4 ns period
  initial begin
    forever #2 aclk = ~aclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // Write both channels, hold each until taken, then wait response
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      num_errors++;
      conclude();
    end
  endtask

  // Read one word, hold request until taken
  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      num_errors++;
      conclude();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    chk("group0 reset", d, PWP_GRP0_RESET);
    rd(8'h10, d, r);
    chk("group1 reset", d, PWP_GRP1_RESET);
    // Table rows, read back through the other view
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, ROWS[i].s, r);
      chk("bresp", 32'(r), 32'(PWP_RESP_OKAY));
      rd(ROWS[i].a ^ 8'h04, d, r);
      chk("rdata", d, ROWS[i].a[4] ? ROWS[i].e1 : ROWS[i].e0);
      chk("prot1", grp1_prot, ROWS[i].e1);
      chk("grant0", grp0_wr_grant, ~ROWS[i].e0);
      chk("deny1", grp1_wr_deny, ROWS[i].e1);
    end
    // Unmapped place: refused, nothing stored
    wr(8'h20, 32'hFFFFFFFF, 4'hF, r);
    chk("bad bresp", 32'(r), 32'(PWP_RESP_SLVERR));
    chk("prot0 kept", grp0_prot, 32'h00000066);
    rd(8'h24, d, r);
    chk("bad rdata", d, 32'h00000000);
    chk("bad rresp", 32'(r), 32'(PWP_RESP_SLVERR));
    // All ones into group zero set: bit 0 and bits 7 to 31 stay clear
    wr(8'h04, 32'hFFFFFFFF, 4'hF, r);
    chk("set0 bresp", 32'(r), 32'(PWP_RESP_OKAY));
    rd(8'h00, d, r);
    chk("unused0", d, PWP_GRP0_MASK);
    // Mixed requests: protected bits denied, open bits granted
    @(posedge aclk);
    grp0_wr_req <= 32'h0000008B;
    grp1_wr_req <= 32'h00000006;
    repeat (2) @(posedge aclk);
    chk("grant0 mix", grp0_wr_grant, 32'h00000081);
    chk("deny0 mix", grp0_wr_deny, 32'h0000000A);
    chk("grant1 mix", grp1_wr_grant, 32'h00000006);
    chk("deny1 mix", grp1_wr_deny, 32'h00000000);
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("prot0 rst", grp0_prot, PWP_GRP0_RESET);
    chk("prot1 rst", grp1_prot, PWP_GRP1_RESET);
    // Gates follow the reset state one edge later
    @(posedge aclk);
    chk("grant0 rst", grp0_wr_grant, 32'h0000008B);
    chk("grant1 rst", grp1_wr_grant, 32'h00000004);
    chk("deny1 rst", grp1_wr_deny, 32'h00000002);
    rd(8'h14, d, r);
    chk("rst rdata", d, PWP_GRP1_RESET);
    conclude();
  end
endmodule
